// >>> design/stm_timer.sv
// What this block does
// - counter clock picked from eight codes: divided, system, sub, pin edges
// - ten-bit counter counts only upward on each selected clock tick
// - period value compared with counter's top three bits, with the low seven bits zero
// - compare-A value compared with all ten counter bits
// - on bit rising clears counter and starts it; single pulse trigger also clears it
// - on bit falling stops counting and holds counter value
// - pause holds counter, though a single pulse trigger still clears it; clearing pause resumes from that value
// - overflow or selected match clears counter and raises an event
// - separate events for compare-A match and period match
// - compare mode: on bit rising restores output to its initial level
// - inverted output pin always opposite of timer output pin
// - compare mode: match drives output low, high or toggles
// - capture mode: rising, falling or both edges of capture pin
// - single pulse mode: external clock pin is the start trigger
// - compare-A low byte write goes only to shared holding buffer
// - compare-A high byte write stores high byte and copies buffer to low byte
// - high byte read returns high byte and loads low byte into buffer
// - low byte read returns the holding buffer
// - counter readable only; compare-A readable and writable
// - period match every code times 128 ticks; zero means 1024
// - clear select picks compare-A or period/overflow clearing in compare and timer modes
module stm_timer
  import stm_pkg::*;
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // timer pins
  input  wire logic        i_ext_clock_trigger_pin,
  input  wire logic        i_capture_input_pin,
  output logic             o_timer_output_pin,
  output logic             o_inverted_output_pin,
  // match events
  output logic             o_irq_compare_a,
  output logic             o_irq_period
);

  ////////////////////////////////////////////////////////////////////////////
  // prescaler for divided and sub clocks
  logic [5:0] pre_q;
  logic [5:0] pre_d;
  logic [9:0] sub_q;
  logic [9:0] sub_d;

  always_comb begin
    pre_d = pre_q + 6'h01;
    sub_d = (sub_q == SUB_LAST) ? 10'h000 : sub_q + 10'h001;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pre_q <= 6'h00;
      sub_q <= 10'h000;
    end else begin
      pre_q <= pre_d;
      sub_q <= sub_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main state
  ctrl0_s      c0_q;
  ctrl0_s      c0_d;
  ctrl1_s      c1_q;
  ctrl1_s      c1_d;
  logic [9:0]  cnt_q;
  logic [9:0]  cnt_d;
  logic [9:0]  compare_a_value_q;
  logic [9:0]  compare_a_value_d;
  logic [7:0]  buf_q;
  logic [7:0]  buf_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic        ext_prev_q;
  logic        cap_prev_q;
  logic        out_q;
  logic        out_d;
  logic        tp_q;
  logic        tpb_q;
  logic        pulse_q;
  logic        pulse_d;
  logic        irq_a_q;
  logic        irq_a_d;
  logic        irq_p_q;
  logic        irq_p_d;

  logic        acc_go;
  logic        wr;
  logic        rd;
  logic        unmapped;
  logic [31:0] rdata;
  logic        on_rise;
  logic        tick;
  logic        running;
  logic        count_step;
  logic [10:0] inc;
  logic        hit_a;
  logic        hit_p;
  logic        clr_on_a;
  logic        ext_rise;
  logic        ext_fall;
  logic        cap_ev;
  logic        single_mode;
  logic        active;
  ctrl0_s      wr_c0;

  always_comb begin
    // one wait state so that read data comes from a flip-flop;
    // writes land at the completing edge, where pready is seen high
    acc_go    = i_psel & i_penable & ~pready_q;
    wr        = i_psel & i_penable & pready_q & i_pwrite;
    rd        = acc_go & ~i_pwrite;
    wr_c0     = ctrl0_s'(i_pwdata[7:0]);
    c0_d      = c0_q;
    c1_d      = c1_q;
    compare_a_value_d    = compare_a_value_q;
    buf_d     = buf_q;
    rdata     = 32'h0000_0000;
    unmapped  = 1'b0;
    on_rise   = 1'b0;

    if (i_paddr == ADDR_CTRL0) begin
      rdata = {24'h00_0000, c0_q};
      if (wr) begin
        c0_d    = wr_c0;
        on_rise = wr_c0.module_on_bit & ~c0_q.module_on_bit;
      end
    end else if (i_paddr == ADDR_CTRL1) begin
      rdata = {24'h00_0000, c1_q};
      if (wr) begin
        c1_d = ctrl1_s'(i_pwdata[7:0]);
      end
    end else if (i_paddr == ADDR_CNT_LO) begin
      rdata = {24'h00_0000, buf_q};
    end else if (i_paddr == ADDR_CNT_HI) begin
      rdata = {30'h0000_0000, cnt_q[9:8]};
      if (rd) begin
        buf_d = cnt_q[7:0];
      end
    end else if (i_paddr == ADDR_CMPA_LO) begin
      rdata = {24'h00_0000, buf_q};
      if (wr) begin
        buf_d = i_pwdata[7:0];
      end
    end else if (i_paddr == ADDR_CMPA_HI) begin
      rdata = {30'h0000_0000, compare_a_value_q[9:8]};
      if (wr) begin
        compare_a_value_d = {i_pwdata[1:0], buf_q};
      end else if (rd) begin
        buf_d = compare_a_value_q[7:0];
      end
    end else begin
      unmapped = 1'b1;
    end

    pready_d  = acc_go;
    pslverr_d = acc_go & unmapped;
    prdata_d  = rd ? rdata : prdata_q;

    //////////////////////////////////////////////////////////////////////////
    // counter clock selection
    ext_rise = i_ext_clock_trigger_pin & ~ext_prev_q;
    ext_fall = ~i_ext_clock_trigger_pin & ext_prev_q;
    case (c0_q.clock_select_field)
      CLK_SYS_DIV4:   tick = (pre_q & DIV4_MASK) == DIV4_MASK;
      CLK_SYS:        tick = 1'b1;
      CLK_HIGH_DIV16: tick = (pre_q & DIV16_MASK) == DIV16_MASK;
      CLK_HIGH_DIV64: tick = pre_q == DIV64_MASK;
      CLK_SUB_A:      tick = sub_q == SUB_LAST;
      CLK_SUB_B:      tick = sub_q == SUB_LAST;
      CLK_EXT_RISE:   tick = ext_rise;
      default:        tick = ext_fall;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // counting and matching
    single_mode = (c1_q.operating_mode_field == MODE_PWM)
                  && (c1_q.pin_function_field == PWM_FN_SINGLE);
    running     = c0_q.module_on_bit & ~c0_q.pause_bit
                  & (~single_mode | pulse_q);
    count_step  = running & tick & ~on_rise;
    inc         = {1'b0, cnt_q} + 11'h001;
    hit_a       = inc[9:0] == compare_a_value_q;
    if (c0_q.period_value_field == PERIOD_OVERFLOW) begin
      hit_p = inc[10];
    end else begin
      hit_p = (inc[9:7] == c0_q.period_value_field)
              && (inc[6:0] == PERIOD_LOW_ZERO);
    end
    clr_on_a = c1_q.clear_select_bit
               && ((c1_q.operating_mode_field == MODE_COMPARE)
                   || (c1_q.operating_mode_field == MODE_TIMER));

    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    irq_a_d = 1'b0;
    irq_p_d = 1'b0;
    if (on_rise) begin
      cnt_d   = CNT_RESET;
      pulse_d = 1'b0;
    end else if (count_step) begin
      irq_a_d = hit_a;
      irq_p_d = hit_p;
      if (clr_on_a ? hit_a : hit_p) begin
        cnt_d = CNT_RESET;
      end else begin
        cnt_d = inc[9:0];
      end
      if (single_mode && hit_a) begin
        pulse_d = 1'b0;
      end
    end
    if (single_mode && c0_q.module_on_bit && ext_rise && !pulse_q) begin
      pulse_d = 1'b1;
      cnt_d   = CNT_RESET;
    end

    //////////////////////////////////////////////////////////////////////////
    // capture input
    cap_ev = 1'b0;
    if (c1_q.operating_mode_field == MODE_CAPTURE && c0_q.module_on_bit) begin
      case (c1_q.pin_function_field)
        CAP_FN_RISE: cap_ev = i_capture_input_pin & ~cap_prev_q;
        CAP_FN_FALL: cap_ev = ~i_capture_input_pin & cap_prev_q;
        CAP_FN_BOTH: cap_ev = i_capture_input_pin ^ cap_prev_q;
        default:     cap_ev = 1'b0;
      endcase
    end
    if (cap_ev) begin
      irq_a_d = 1'b1;
      if (!(wr && i_paddr == ADDR_CMPA_HI)) begin
        compare_a_value_d = cnt_q;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // output level
    out_d  = out_q;
    active = c1_q.output_control_bit;
    case (c1_q.operating_mode_field)
      MODE_COMPARE: begin
        if (on_rise) begin
          out_d = c1_q.output_control_bit;
        end else if (count_step && hit_a) begin
          case (c1_q.pin_function_field)
            PIN_FN_LOW:    out_d = 1'b0;
            PIN_FN_HIGH:   out_d = 1'b1;
            PIN_FN_TOGGLE: out_d = ~out_q;
            default:       out_d = out_q;
          endcase
        end
      end
      MODE_PWM: begin
        case (c1_q.pin_function_field)
          PWM_FN_INACTIVE: out_d = ~active;
          PWM_FN_ACTIVE:   out_d = active;
          PWM_FN_WAVE: begin
            if (c1_q.duty_select_bit) begin
              out_d = (cnt_d[9:7] < c0_q.period_value_field) ? active : ~active;
            end else begin
              out_d = (cnt_d < compare_a_value_q) ? active : ~active;
            end
          end
          default:         out_d = pulse_d ? active : ~active;
        endcase
      end
      default: out_d = out_q;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      c0_q       <= ctrl0_s'(CTRL0_RESET);
      c1_q       <= ctrl1_s'(CTRL1_RESET);
      cnt_q      <= CNT_RESET;
      compare_a_value_q     <= CMPA_RESET;
      buf_q      <= HOLD_RESET;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
      ext_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
      out_q      <= 1'b0;
      tp_q       <= 1'b0;
      tpb_q      <= 1'b1;
      pulse_q    <= 1'b0;
      irq_a_q    <= 1'b0;
      irq_p_q    <= 1'b0;
    end else begin
      c0_q       <= c0_d;
      c1_q       <= c1_d;
      cnt_q      <= cnt_d;
      compare_a_value_q     <= compare_a_value_d;
      buf_q      <= buf_d;
      prdata_q   <= prdata_d;
      pready_q   <= pready_d;
      pslverr_q  <= pslverr_d;
      ext_prev_q <= i_ext_clock_trigger_pin;
      cap_prev_q <= i_capture_input_pin;
      out_q      <= out_d;
      tp_q       <= out_d ^ c1_d.polarity_bit;
      tpb_q      <= ~(out_d ^ c1_d.polarity_bit);
      pulse_q    <= pulse_d;
      irq_a_q    <= irq_a_d;
      irq_p_q    <= irq_p_d;
    end
  end

  assign o_prdata              = prdata_q;
  assign o_pready              = pready_q;
  assign o_pslverr             = pslverr_q;
  assign o_timer_output_pin    = tp_q;
  assign o_inverted_output_pin = tpb_q;
  assign o_irq_compare_a       = irq_a_q;
  assign o_irq_period          = irq_p_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  AST_COUNT_UP: assert property (
    !$stable(cnt_q) |-> (cnt_q == 10'($past(cnt_q) + 10'h001)) || (cnt_q == CNT_RESET))
    else $error("counter moved other than up or to zero");

  AST_PERIOD_CLEAR: assert property (
    count_step && !clr_on_a && c0_q.period_value_field != PERIOD_OVERFLOW
    && cnt_q == {c0_q.period_value_field - 3'h1, 7'h7F}
    |=> cnt_q == CNT_RESET && o_irq_period)
    else $error("period match did not clear counter with event");

  AST_CMPA_EVENT: assert property (
    count_step && inc[9:0] == compare_a_value_q |=> o_irq_compare_a)
    else $error("compare-A match gave no event");

  AST_ON_RISE: assert property (
    on_rise |=> cnt_q == CNT_RESET ##1 $past(cnt_q) == CNT_RESET)
    else $error("counter not cleared when switched on");

  AST_OFF_HOLD: assert property (
    !c0_q.module_on_bit && !on_rise |=> $stable(cnt_q))
    else $error("counter moved while switched off");

  AST_PAUSE_HOLD: assert property (
    c0_q.pause_bit && !on_rise && !single_mode |=> $stable(cnt_q))
    else $error("counter moved while paused");

  AST_INVERSE: assert property (
    o_inverted_output_pin == !o_timer_output_pin)
    else $error("inverted pin not the inverse");

  AST_EVENT_CAUSE: assert property (
    $rose(o_irq_period) |-> $past(count_step))
    else $error("period event without a counter step");

  AST_LOW_WRITE: assert property (
    wr && i_paddr == ADDR_CMPA_LO && !cap_ev |=> $stable(compare_a_value_q)
    && buf_q == $past(i_pwdata[7:0]))
    else $error("low byte write reached compare register");

  AST_HIGH_WRITE: assert property (
    wr && i_paddr == ADDR_CMPA_HI |=> compare_a_value_q == {$past(i_pwdata[1:0]), $past(buf_q)})
    else $error("high byte write did not merge holding buffer");

  AST_LOW_READ: assert property (
    rd && i_paddr == ADDR_CNT_LO |=> o_prdata == {24'h00_0000, $past(buf_q)} && o_pready)
    else $error("low byte read did not return holding buffer");

endmodule

// >>> include/stm_pkg.sv
package stm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int unsigned MCLK_HZ      = 20_000_000;
  localparam int unsigned SUB_CLOCK_HZ = 32_768;
  localparam int unsigned SUB_DIV      = MCLK_HZ / SUB_CLOCK_HZ;
  localparam logic [9:0]  SUB_LAST     = 10'(SUB_DIV - 1);
  localparam logic [5:0]  DIV4_MASK    = 6'h03;
  localparam logic [5:0]  DIV16_MASK   = 6'h0F;
  localparam logic [5:0]  DIV64_MASK   = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO  = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI  = 8'h0C;
  localparam logic [7:0] ADDR_CMPA_LO = 8'h10;
  localparam logic [7:0] ADDR_CMPA_HI = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [9:0] CNT_RESET   = 10'h000;
  localparam logic [9:0] CMPA_RESET  = 10'h000;
  localparam logic [7:0] HOLD_RESET  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field codes
  localparam logic [2:0] PERIOD_OVERFLOW = 3'h0;
  localparam logic [6:0] PERIOD_LOW_ZERO = 7'h00;
  localparam logic [1:0] PIN_FN_KEEP     = 2'h0;
  localparam logic [1:0] PIN_FN_LOW      = 2'h1;
  localparam logic [1:0] PIN_FN_HIGH     = 2'h2;
  localparam logic [1:0] PIN_FN_TOGGLE   = 2'h3;
  localparam logic [1:0] PWM_FN_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_FN_ACTIVE   = 2'h1;
  localparam logic [1:0] PWM_FN_WAVE     = 2'h2;
  localparam logic [1:0] PWM_FN_SINGLE   = 2'h3;
  localparam logic [1:0] CAP_FN_RISE     = 2'h0;
  localparam logic [1:0] CAP_FN_FALL     = 2'h1;
  localparam logic [1:0] CAP_FN_BOTH     = 2'h2;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_CAPTURE,
    MODE_PWM,
    MODE_TIMER
  } mode_e;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4,
    CLK_SYS,
    CLK_HIGH_DIV16,
    CLK_HIGH_DIV64,
    CLK_SUB_A,
    CLK_SUB_B,
    CLK_EXT_RISE,
    CLK_EXT_FALL
  } clk_sel_e;

  typedef struct packed {
    logic       pause_bit;
    clk_sel_e   clock_select_field;
    logic       module_on_bit;
    logic [2:0] period_value_field;
  } ctrl0_s;

  typedef struct packed {
    mode_e      operating_mode_field;
    logic [1:0] pin_function_field;
    logic       output_control_bit;
    logic       polarity_bit;
    logic       duty_select_bit;
    logic       clear_select_bit;
  } ctrl1_s;

endpackage

// >>> tb/standard_timer_module_10bit_tb.sv
module standard_timer_module_10bit_tb
  import stm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic        ext_run, cap_level, ext_pin, cap_pin, tpin, ipin, irq_a, irq_p;
  logic [7:0]  paddr, ext_half;
  logic [31:0] pwdata, prdata, rdata;
  int          failures, n_checks, seed, m_c0, m_c1, m_cmpa, m_hold;

  always #25 mclk = ~mclk;

  stm_timer i_dut (
    .i_mclk                  (mclk),
    .i_rst_n                 (rst_n),
    .i_psel                  (psel),
    .i_penable               (penable),
    .i_pwrite                (pwrite),
    .i_paddr                 (paddr),
    .i_pwdata                (pwdata),
    .o_prdata                (prdata),
    .o_pready                (pready),
    .o_pslverr               (pslverr),
    .i_ext_clock_trigger_pin (ext_pin),
    .i_capture_input_pin     (cap_pin),
    .o_timer_output_pin      (tpin),
    .o_inverted_output_pin   (ipin),
    .o_irq_compare_a         (irq_a),
    .o_irq_period            (irq_p)
  );

  stm_pins_model i_pins (
    .i_mclk                  (mclk),
    .i_ext_run               (ext_run),
    .i_ext_half              (ext_half),
    .i_cap_level             (cap_level),
    .o_ext_clock_trigger_pin (ext_pin),
    .o_capture_input_pin     (cap_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    if (rst_n === 1'b1) begin
      n_checks++;
      if (ipin !== ~tpin) begin
        failures++;
        $display("[ERR] %0t inverted pin not opposite", $time);
      end
    end
  end

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic tmo();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    final_report();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) tmo();
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register model: shared low-byte buffer
  task automatic wr(input logic [7:0] a, input int d);
    apb(1'b1, a, 8'(d));
    if (a == ADDR_CTRL0) m_c0 = d;
    if (a == ADDR_CTRL1) m_c1 = d;
    if (a == ADDR_CMPA_LO) m_hold = d;
    if (a == ADDR_CMPA_HI) m_cmpa = (d % 4) * 256 + m_hold;
  endtask

  task automatic rd(input logic [7:0] a);
    int e;
    e = (a == ADDR_CTRL0) ? m_c0 : (a == ADDR_CTRL1) ? m_c1 :
        (a == ADDR_CMPA_HI) ? m_cmpa / 256 : m_hold;
    apb(1'b0, a, 8'h00);
    chk(rdata, 32'(e), "register read");
    if (a == ADDR_CMPA_HI) m_hold = m_cmpa % 256;
  endtask

  task automatic rd_cnt(output int v);
    apb(1'b0, ADDR_CNT_HI, 8'h00);
    v = int'(rdata[1:0]) * 256;
    apb(1'b0, ADDR_CNT_LO, 8'h00);
    v = v + int'(rdata[7:0]);
    m_hold = int'(rdata[7:0]);
  endtask

  // s: 0 compare-A event, 1 period event, 2 output pin
  task automatic wait_sig(input int s, input logic l, input int lim, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while ((s == 0 ? irq_a : s == 1 ? irq_p : tpin) !== l && k < lim);
    if (k >= lim) tmo();
  endtask

  task automatic count_irq(output int c);
    c = 0;
    repeat (20) begin
      @(posedge mclk);
      if (irq_a === 1'b1) c++;
    end
  endtask

  function automatic int div(input int c);
    return (c == 0) ? 4 : (c == 1) ? 1 : (c == 2) ? 16 : (c == 3) ? 64 :
           (c < 6) ? int'(SUB_DIV) : 16;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int v, n, e, w0, w1;
    mclk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, ext_run, cap_level} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_half = 8'h07;
    {failures, n_checks, m_c0, m_c1, m_cmpa, m_hold} = '0;
    seed = 92;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    chk({ipin, tpin}, 2'b10, "pins after reset");
    rd(ADDR_CTRL0);
    rd(ADDR_CTRL1);
    rd(ADDR_CMPA_HI);
    rd(ADDR_CMPA_LO);
    wr(ADDR_CNT_LO, 8'hAA);
    wr(ADDR_CNT_HI, 3);
    rd_cnt(v);
    chk(v, 0, "counter after write");
    apb(1'b0, 8'h3C, 8'h00);
    chk(rerr, 1, "unmapped address");
    repeat (4) begin
      v = $random(seed) & 1023;
      wr(ADDR_CMPA_LO, v % 256);
      rd(ADDR_CMPA_HI);
      rd(ADDR_CMPA_LO);
      wr(ADDR_CMPA_LO, v % 256);
      wr(ADDR_CMPA_HI, v / 256);
      rd(ADDR_CMPA_HI);
      rd(ADDR_CMPA_LO);
    end
    // clock sources, clear on compare-A of 4
    wr(ADDR_CMPA_LO, 4);
    wr(ADDR_CMPA_HI, 0);
    wr(ADDR_CTRL1, 8'hC1);
    ext_run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CTRL0, c * 16 + 8);
      wait_sig(0, 1'b1, 3000, n);
      wait_sig(0, 1'b1, 3000, n);
      chk(n, 4 * div(c), "compare-A interval");
    end
    ext_run <= 1'b0;
    wr(ADDR_CTRL1, 8'hC0);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_CTRL0, 8'h18 + p);
      wait_sig(1, 1'b1, 1100, n);
      wait_sig(1, 1'b1, 1100, n);
      chk(n, (p == 0) ? 1024 : p * 128, "period interval");
    end
    // pause, off and restart
    wr(ADDR_CMPA_LO, 8'hE8);
    wr(ADDR_CMPA_HI, 3);
    wr(ADDR_CTRL1, 8'hC1);
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_CTRL0, 8'h18);
    repeat (40 + ($random(seed) & 63)) @(posedge mclk);
    wr(ADDR_CTRL0, 8'h98);
    rd_cnt(w0);
    repeat (20) @(posedge mclk);
    rd_cnt(w1);
    chk(w1, w0, "paused counter");
    wr(ADDR_CTRL0, 8'h18);
    repeat (30) @(posedge mclk);
    rd(ADDR_CNT_LO);
    rd_cnt(v);
    chk(32'(v - w1 > 30 && v - w1 < 60), 1, "counter resumed");
    wr(ADDR_CTRL0, 8'h10);
    rd_cnt(w0);
    repeat (20) @(posedge mclk);
    rd_cnt(w1);
    chk(32'(w1 == w0 && w1 > 40), 1, "counter held while off");
    wr(ADDR_CTRL0, 8'h18);
    rd_cnt(v);
    chk(32'(v < 12), 1, "counter restarted");
    // compare output functions
    for (int f = 0; f < 4; f++) begin
      e = (f == 2) ? 0 : 1;
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, f * 16 + e * 8 + 1);
      wr(ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge mclk);
      chk(tpin, e, "initial level");
      wait_sig(0, 1'b1, 1100, n);
      repeat (2) @(posedge mclk);
      chk(tpin, (f % 2 == 0) ? 1 : 0, "level after match");
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL0, 8'h18);
      repeat (3) @(posedge mclk);
      chk(tpin, e, "level restored");
    end
    // capture edges, counter paused so no compare-A match can add events
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CTRL0, 8'h10);
      wr(ADDR_CTRL1, 8'h40 + f * 16);
      wr(ADDR_CTRL0, 8'hC8);
      cap_level <= 1'b1;
      count_irq(n);
      cap_level <= 1'b0;
      count_irq(v);
      chk(n * 2 + v, (f == 0) ? 2 : (f == 1) ? 1 : (f == 2) ? 3 : 0, "capture");
    end
    // single pulse started by the external pin
    wr(ADDR_CTRL0, 8'h10);
    wr(ADDR_CTRL1, 8'hB8);
    wr(ADDR_CMPA_LO, 20);
    wr(ADDR_CMPA_HI, 0);
    wr(ADDR_CTRL0, 8'h18);
    ext_half <= 8'h3F;
    ext_run <= 1'b1;
    repeat (40) @(posedge mclk);
    chk(tpin, 0, "idle before trigger");
    wait_sig(2, 1'b1, 60, n);
    wait_sig(2, 1'b0, 60, n);
    chk(32'(n > 15 && n < 25), 1, "pulse width");
    ext_run <= 1'b0;
    // fixed pwm levels, plain and with polarity inverted
    for (int f = 0; f < 4; f++) begin
      wr(ADDR_CTRL1, 8'h80 + (f % 2) * 16 + 8 + (f / 2) * 4);
      repeat (2) @(posedge mclk);
      chk(tpin, (f % 2) ^ (f / 2), "fixed level");
    end
    final_report();
  end
endmodule

// >>> tb/stm_pins_model.sv
module stm_pins_model (
  // bench control
  input  wire logic       i_mclk,
  input  wire logic       i_ext_run,
  input  wire logic [7:0] i_ext_half,
  input  wire logic       i_cap_level,
  // pins toward the timer
  output logic            o_ext_clock_trigger_pin,
  output logic            o_capture_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] half_q;

  initial begin
    half_q = 8'h00;
    o_ext_clock_trigger_pin = 1'b0;
    o_capture_input_pin = 1'b0;
  end

  // edge source that stands still low while stopped
  always @(posedge i_mclk) begin
    if (i_ext_run !== 1'b1) begin
      half_q <= 8'h00;
      o_ext_clock_trigger_pin <= 1'b0;
    end else if (half_q == i_ext_half) begin
      half_q <= 8'h00;
      o_ext_clock_trigger_pin <= ~o_ext_clock_trigger_pin;
    end else begin
      half_q <= half_q + 8'h01;
    end
    o_capture_input_pin <= i_cap_level;
  end
endmodule
